// ===== smtwt_consts.svh
`ifndef SMTWT_CONSTS_SVH
`define SMTWT_CONSTS_SVH
// Device type code; value is arbitrary.
`define SMTWT_TYPE_CODE 4'h5
`define SMTWT_BITS_PER_UNIT 4'h8
`define SMTWT_ACK_BIT 4'h8
`define SMTWT_MEM_ADDR_BYTES 2'h2
`define SMTWT_FILTER_LEN 2'h2
`endif

// ===== smtwt_pkg.sv
package smtwt_pkg;
   typedef enum logic [4:0] {
      SMTWT_IDLE = 5'h01,
      SMTWT_RX = 5'h02,
      SMTWT_TX = 5'h04,
      SMTWT_ACK = 5'h08,
      SMTWT_WAIT = 5'h10
   } smtwt_state_e;
   typedef logic [7:0] smtwt_byte_t;
endpackage

// ===== smtwt_filter.sv
`include "smtwt_consts.svh"
// ***********************************************
// Two-stage synchroniser followed by a glitch filter.
// ***********************************************
module smtwt_filter (
   input wire logic clk,
   input wire logic resetn,
   input wire logic din,
   output logic dout
);
   logic s1;
   logic s2;
   logic [1:0] cnt;
   always_ff @(posedge clk) begin
      if (!resetn) begin
         s1 <= 1'b1;
         s2 <= 1'b1;
      end else begin
         s1 <= din;
         s2 <= s1;
      end
   end
   // The output follows only a level that stays for the filter length.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         cnt <= 2'h0;
         dout <= 1'b1;
      end else if (s2 == dout) begin
         cnt <= 2'h0;
      end else if (cnt == `SMTWT_FILTER_LEN - 2'h1) begin
         cnt <= 2'h0;
         dout <= s2;
      end else begin
         cnt <= cnt + 2'h1;
      end
   end
endmodule // smtwt_filter

// ===== smtwt_target.sv
// What this block does
// - Sample data on rising, change on falling clock.
// - Data line only pulled low or released.
// - Respond only when select code matches pins.
// - Unconnected select pins read as low.
// - Write protect high refuses all memory writes.
// - Reads proceed whatever the write protect level.
// - Unconnected write protect reads as low.
// - Data changes only while clock is low.
// - Data falling with clock high is start.
// - Stop ends any access, returns to standby.
// - Writes need no programming delay after stop.
// - Receiver acknowledges each byte on ninth clock.
// - Transmitter releases data during the ninth clock.
// - Stop before acknowledge abandons operation to standby.
// - After not-acknowledge, release the data line.
// - First byte: type, select two-one-zero, direction.
// - Eighth address bit zero writes, one reads.
// - Mismatching type or select stays silent in standby.
// - Two memory address bytes follow, each acknowledged.
`include "smtwt_consts.svh"
module smtwt_target (
   input wire logic clk,
   input wire logic resetn,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic select_pin_0,
   input wire logic select_pin_1,
   input wire logic select_pin_2,
   input wire logic write_protect,
   output smtwt_pkg::smtwt_byte_t mem_addr_hi,
   output smtwt_pkg::smtwt_byte_t mem_addr_lo,
   output logic addr_load,
   output smtwt_pkg::smtwt_byte_t wr_data,
   output logic wr_strobe,
   output logic rd_strobe,
   input wire smtwt_pkg::smtwt_byte_t rd_data,
   output logic busy
);
   import smtwt_pkg::*;

   // ***********************************************
   // Line conditioning and edge detection.
   // ***********************************************
   logic scl_f;
   logic sda_f;
   logic scl_d;
   logic sda_d;
   logic [2:0] sel_s1;
   logic [2:0] sel_s2;
   logic wp_s1;
   logic wp_s2;
   smtwt_filter u_scl (.clk(clk), .resetn(resetn), .din(scl_in), .dout(scl_f));
   smtwt_filter u_sda (.clk(clk), .resetn(resetn), .din(sda_in), .dout(sda_f));

   always_ff @(posedge clk) begin
      if (!resetn) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_d <= scl_f;
         sda_d <= sda_f;
      end
   end

   // Straps and write protect are pins; an open pin is pulled low outside.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         sel_s1 <= 3'h0;
         sel_s2 <= 3'h0;
         wp_s1 <= 1'b0;
         wp_s2 <= 1'b0;
      end else begin
         sel_s1 <= {select_pin_2, select_pin_1, select_pin_0};
         sel_s2 <= sel_s1;
         wp_s1 <= write_protect;
         wp_s2 <= wp_s1;
      end
   end

   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;
   assign scl_rise = scl_f && !scl_d;
   assign scl_fall = !scl_f && scl_d;
   assign start_cond = scl_f && scl_d && sda_d && !sda_f;
   assign stop_cond = scl_f && scl_d && !sda_d && sda_f;

   // ***********************************************
   // Transfer sequencing.
   // ***********************************************
   smtwt_state_e state;
   smtwt_byte_t shreg;
   logic [3:0] bitcnt;
   logic [1:0] phase;
   logic read_dir;
   logic ack_low;
   logic ack_rcv;
   logic addressed;
   logic ack_given;
   logic match;
   assign match = (shreg[7:4] == `SMTWT_TYPE_CODE) && (shreg[3:1] == sel_s2);

   always_ff @(posedge clk) begin
      if (!resetn || stop_cond) begin
         state <= SMTWT_IDLE;
         bitcnt <= 4'h0;
         phase <= 2'h0;
         read_dir <= 1'b0;
         ack_low <= 1'b0;
         ack_rcv <= 1'b0;
         addressed <= 1'b0;
         ack_given <= 1'b0;
         shreg <= 8'h00;
      end else if (start_cond) begin
         state <= SMTWT_RX;
         bitcnt <= 4'h0;
         phase <= 2'h0;
         addressed <= 1'b0;
         ack_low <= 1'b0;
         ack_given <= 1'b0;
      end else begin
         case (state)
            SMTWT_IDLE: begin
               bitcnt <= 4'h0;
            end
            SMTWT_RX: begin
               if (scl_rise) begin
                  shreg <= {shreg[6:0], sda_f};
                  bitcnt <= bitcnt + 4'h1;
               end else if (scl_fall && bitcnt == `SMTWT_BITS_PER_UNIT) begin
                  bitcnt <= 4'h0;
                  state <= SMTWT_ACK;
                  ack_given <= 1'b0;
                  if (!addressed) begin
                     ack_low <= match;
                     read_dir <= shreg[0];
                     addressed <= match;
                     phase <= 2'h0;
                  end else begin
                     ack_low <= 1'b1;
                     if (phase != `SMTWT_MEM_ADDR_BYTES) begin
                        phase <= phase + 2'h1;
                     end
                  end
               end
            end
            SMTWT_ACK: begin
               // Ninth clock: falling edge ends it.
               if (scl_rise) begin
                  ack_given <= 1'b1;
               end else if (scl_fall && ack_given) begin
                  ack_low <= 1'b0;
                  if (!addressed) begin
                     state <= SMTWT_IDLE;
                  end else if (read_dir) begin
                     state <= SMTWT_TX;
                     shreg <= rd_data;
                  end else begin
                     state <= SMTWT_RX;
                  end
               end
            end
            SMTWT_TX: begin
               if (scl_fall) begin
                  if (bitcnt == `SMTWT_BITS_PER_UNIT - 4'h1) begin
                     state <= SMTWT_WAIT;
                     bitcnt <= 4'h0;
                     ack_given <= 1'b0;
                  end else begin
                     shreg <= {shreg[6:0], 1'b0};
                     bitcnt <= bitcnt + 4'h1;
                  end
               end
            end
            SMTWT_WAIT: begin
               if (scl_rise) begin
                  ack_rcv <= !sda_f;
                  ack_given <= 1'b1;
               end else if (scl_fall && ack_given) begin
                  if (ack_rcv) begin
                     state <= SMTWT_TX;
                     shreg <= rd_data;
                  end else begin
                     state <= SMTWT_IDLE;
                  end
               end
            end
            default: begin
               state <= SMTWT_IDLE;
            end
         endcase
      end
   end

   // ***********************************************
   // Memory side strobes, each one clock wide.
   // ***********************************************
   logic byte_done;
   assign byte_done = (state == SMTWT_RX) && scl_fall && (bitcnt == `SMTWT_BITS_PER_UNIT) && addressed;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         mem_addr_hi <= 8'h00;
         mem_addr_lo <= 8'h00;
         addr_load <= 1'b0;
         wr_data <= 8'h00;
         wr_strobe <= 1'b0;
         rd_strobe <= 1'b0;
         busy <= 1'b0;
      end else begin
         addr_load <= 1'b0;
         wr_strobe <= 1'b0;
         rd_strobe <= 1'b0;
         busy <= (state != SMTWT_IDLE);
         if (byte_done && !stop_cond && !start_cond) begin
            if (phase == 2'h0) begin
               mem_addr_hi <= shreg;
            end else if (phase == 2'h1) begin
               mem_addr_lo <= shreg;
               addr_load <= 1'b1;
            end else begin
               wr_data <= shreg;
               // Write completes at once; nothing is held after stop.
               wr_strobe <= !wp_s2;
            end
         end
         // Each byte sent advances the read address regardless of protect.
         if (!stop_cond && !start_cond && scl_fall &&
             ((state == SMTWT_ACK && addressed && read_dir && ack_given) ||
              (state == SMTWT_WAIT && ack_given && ack_rcv))) begin
            rd_strobe <= 1'b1;
         end
      end
   end

   // ***********************************************
   // Open-drain data driver, updated on falling clock and released on start or stop.
   // ***********************************************
   logic next_pull;
   always_comb begin
      next_pull = 1'b0;
      if (state == SMTWT_RX && bitcnt == `SMTWT_BITS_PER_UNIT) begin
         next_pull = addressed || match;
         if (!addressed) begin
            next_pull = match;
         end
      end else if (state == SMTWT_ACK && !ack_given) begin
         next_pull = ack_low;
      end else if (state == SMTWT_ACK && ack_given && addressed && read_dir) begin
         next_pull = !rd_data[7];
      end else if (state == SMTWT_TX) begin
         next_pull = (bitcnt == `SMTWT_BITS_PER_UNIT - 4'h1) ? 1'b0 : !shreg[6];
      end else if (state == SMTWT_WAIT && ack_given && ack_rcv) begin
         next_pull = !rd_data[7];
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn || stop_cond || start_cond) begin
         sda_oe <= 1'b0;
      end else if (scl_fall) begin
         sda_oe <= next_pull;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         sda_out <= 1'b0;
      end else begin
         sda_out <= 1'b0;
      end
   end
endmodule // smtwt_target

// ===== smtwt_chk_sva.sv
// ***
// Port checker for the two-wire target.
// ***
module smtwt_chk (
   input wire logic clk,
   input wire logic resetn,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic write_protect,
   input wire logic addr_load,
   input wire logic wr_strobe,
   input wire logic rd_strobe,
   input wire logic busy
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   logic [2:0] wp_cnt;
   // Counts how long protect has been held high, so synchroniser delay is allowed for.
   always_ff @(posedge clk) begin
      if (!write_protect) wp_cnt <= 3'h0;
      else if (wp_cnt != 3'h7) wp_cnt <= wp_cnt + 3'h1;
   end
   property p_open_drain; sda_out == 1'b0; endproperty
   a_open_drain: assert property (p_open_drain) else $error("data line driven high");
   property p_idle_released; !busy |-> !sda_oe; endproperty
   a_idle_released: assert property (p_idle_released) else $error("idle but pulling low");
   property p_wr_pulse; wr_strobe |=> !wr_strobe; endproperty
   a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe too long");
   property p_rd_pulse; rd_strobe |=> !rd_strobe; endproperty
   a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe too long");
   property p_addr_gap; addr_load |=> (!addr_load && !wr_strobe) [*8]; endproperty
   a_addr_gap: assert property (p_addr_gap) else $error("strobe too soon after address");
   property p_wp_block; wr_strobe |-> wp_cnt != 3'h7; endproperty
   a_wp_block: assert property (p_wp_block) else $error("write while protected");
   property p_stop_idle; scl_in && $past(scl_in) && $rose(sda_in) |-> ##[1:12] !busy; endproperty
   a_stop_idle: assert property (p_stop_idle) else $error("stop did not end access");
   property p_start_busy; scl_in && $past(scl_in) && $fell(sda_in) |-> ##[1:12] busy; endproperty
   a_start_busy: assert property (p_start_busy) else $error("start not seen");
   property p_oe_hold; $rose(sda_oe) |-> sda_oe [*4]; endproperty
   a_oe_hold: assert property (p_oe_hold) else $error("low level dropped early");
   c_write: cover property (wr_strobe);
   c_read: cover property (rd_strobe);
   c_addr: cover property (addr_load);
endmodule // smtwt_chk
bind smtwt_target smtwt_chk u_chk (.clk, .resetn, .scl_in, .sda_in, .sda_out, .sda_oe,
   .write_protect, .addr_load, .wr_strobe, .rd_strobe, .busy);

// ===== smtwt_ctrl_model.sv
// ***
// Bus controller model: makes the serial clock and frames.
// ***
module smtwt_ctrl_model (
   output logic scl,
   output logic sda_rel,
   input wire logic sda
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      scl = 1'b1;
      sda_rel = 1'b1;
   end
   task automatic start();
      scl = 1'b0;
      #100 sda_rel = 1'b1;
      #100 scl = 1'b1;
      #160 sda_rel = 1'b0;
      #160;
   endtask
   task automatic stop();
      scl = 1'b0;
      #100 sda_rel = 1'b0;
      #100 scl = 1'b1;
      #160 sda_rel = 1'b1;
      #200;
   endtask
   task automatic xfer(input logic [8:0] tx, input int n, output logic [8:0] rx);
      rx = 9'h1FF;
      for (int i = 0; i < n; i++) begin
         scl = 1'b0;
         #100 sda_rel = tx[8-i];
         #100 scl = 1'b1;
         #60 rx[8-i] = sda;
         #60;
      end
   endtask
endmodule // smtwt_ctrl_model

// ===== serial_memory_two_wire_target_tb.sv
`include "smtwt_consts.svh"
// ***
// Testbench for the two-wire target.
// ***
module serial_memory_two_wire_target_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import smtwt_pkg::*;
   typedef struct packed {logic [2:0] pins; logic [3:0] tc; logic [2:0] code; logic prot; logic ack;} smtwt_row_s;
   smtwt_row_s rows [5] = '{'{3'h0, `SMTWT_TYPE_CODE, 3'h0, 1'b0, 1'b1},
      '{3'h5, `SMTWT_TYPE_CODE, 3'h5, 1'b0, 1'b1}, '{3'h2, `SMTWT_TYPE_CODE, 3'h3, 1'b0, 1'b0},
      '{3'h7, `SMTWT_TYPE_CODE ^ 4'h8, 3'h7, 1'b0, 1'b0}, '{3'h6, `SMTWT_TYPE_CODE, 3'h6, 1'b1, 1'b1}};
   logic [7:0] by [3] = '{8'h7F, 8'h80, 8'hC3};
   logic clk = 1'b0, resetn = 1'b0, wp = 1'b0;
   logic [2:0] sel = 3'h0;
   smtwt_byte_t rd_data = 8'h3C, mem_addr_hi, mem_addr_lo, wr_data;
   logic scl, sda_rel, sda, sda_out, sda_oe, addr_load, wr_strobe, rd_strobe, busy;
   logic [8:0] rx;
   int n_mismatch = 0, num_checks = 0, n_wr = 0, n_ld = 0, wr0, ld0;
   // Pull-up on the data line: low only while some party pulls it.
   assign sda = sda_rel & (sda_oe ? sda_out : 1'b1);
   always #20 clk = ~clk;
   always @(posedge clk) begin
      n_wr <= n_wr + int'(wr_strobe);
      n_ld <= n_ld + int'(addr_load);
      if (rd_strobe) rd_data <= rd_data + 8'h01;
   end
   smtwt_ctrl_model m (.scl(scl), .sda_rel(sda_rel), .sda(sda));
   smtwt_target DUT (.clk(clk), .resetn(resetn), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
      .select_pin_0(sel[0]), .select_pin_1(sel[1]), .select_pin_2(sel[2]), .write_protect(wp),
      .mem_addr_hi(mem_addr_hi), .mem_addr_lo(mem_addr_lo), .addr_load(addr_load), .wr_data(wr_data),
      .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data(rd_data), .busy(busy));
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      if (n_mismatch == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic begin_frame(input logic [2:0] p, input logic w);
      @(posedge clk);
      sel <= p;
      wp <= w;
      #7;
      wr0 = n_wr;
      ld0 = n_ld;
      m.start();
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      conclude();
   end
   initial begin
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      @(negedge clk);
      chk({11'h000, sda_oe, busy, wr_strobe, rd_strobe, addr_load}, 16'h0000);
      foreach (rows[k]) begin
         begin_frame(rows[k].pins, rows[k].prot);
         m.xfer({rows[k].tc, rows[k].code, 1'b0, 1'b1}, 9, rx);
         chk(16'(rx[0]), 16'(!rows[k].ack));
         for (int b = 0; b < 3; b++) begin
            m.xfer({by[b] ^ 8'(k), 1'b1}, 9, rx);
            chk(16'(rx[0]), 16'(!rows[k].ack));
         end
         m.stop();
         repeat (4) @(negedge clk);
         chk(16'(busy), 16'h0000);
         chk(16'(n_ld - ld0), 16'(rows[k].ack));
         chk(16'(n_wr - wr0), 16'(rows[k].ack & !rows[k].prot));
         if (rows[k].ack) chk({mem_addr_hi, mem_addr_lo}, {by[0] ^ 8'(k), by[1] ^ 8'(k)});
         if (rows[k].ack && !rows[k].prot) chk(16'(wr_data), 16'(by[2] ^ 8'(k)));
      end
      begin_frame(3'h1, 1'b1);
      m.xfer({`SMTWT_TYPE_CODE, 3'h1, 1'b0, 1'b1}, 9, rx);
      m.xfer(9'h001, 9, rx);
      m.start();
      m.xfer({`SMTWT_TYPE_CODE, 3'h1, 1'b1, 1'b1}, 9, rx);
      chk(16'(rx[0]), 16'h0000);
      m.xfer(9'h1FE, 9, rx);
      chk(16'(rx[8:1]), 16'h003C);
      m.xfer(9'h1FF, 9, rx);
      chk(16'(rx[8:1]), 16'h003D);
      repeat (8) @(negedge clk);
      // The ninth clock is still high here, so only the release can be seen yet.
      chk(16'(sda_oe), 16'h0000);
      m.stop();
      repeat (4) @(negedge clk);
      chk(16'(busy), 16'h0000);
      begin_frame(3'h1, 1'b0);
      m.xfer({`SMTWT_TYPE_CODE, 3'h1, 1'b0, 1'b1}, 9, rx);
      m.xfer(9'h003, 9, rx);
      m.xfer(9'h009, 9, rx);
      m.xfer(9'h1FF, 4, rx);
      m.stop();
      repeat (4) @(negedge clk);
      chk(16'(n_wr - wr0), 16'h0000);
      chk(16'(n_ld - ld0), 16'h0001);
      chk(16'(busy), 16'h0000);
      // Reset in mid-frame while the target is pulling the acknowledge low.
      begin_frame(3'h4, 1'b0);
      m.xfer({`SMTWT_TYPE_CODE, 3'h4, 1'b0, 1'b1}, 9, rx);
      chk(16'(rx[0]), 16'h0000);
      @(posedge clk);
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      @(negedge clk);
      chk({11'h000, sda_oe, busy, wr_strobe, rd_strobe, addr_load}, 16'h0000);
      m.stop();
      begin_frame(3'h4, 1'b0);
      m.xfer({`SMTWT_TYPE_CODE, 3'h4, 1'b0, 1'b1}, 9, rx);
      chk(16'(rx[0]), 16'h0000);
      m.stop();
      repeat (4) @(negedge clk);
      chk(16'(busy), 16'h0000);
      conclude();
   end
endmodule // serial_memory_two_wire_target_tb
